/* File: hdl/lookaside_l2_bus_response.sv */
// bus-side transaction control of the look-aside copy-back cache
// Contract
// - one pipelined address; hold aack until tenure ends
// - own tenure: aack with fourth transfer ack
// - after memory miss: aack after fourth ack
// - write-through taken from flag at start
// - write-through hit, clean miss: drive nothing
// - dirty victim: bus request two clocks later
// - victim into buffer during fill; castout after
// - dirty snoop: retry through cycle after aack
// - bus request rises with retry
// - sample processor request after retry window
// - no processor request: sample grant next cycle
// - processor request: drop request, ignore grant
// - processor writeback: update on read, invalidate write
// - first hit beat gated by processor data grant; later beats ungated
// - hit claim from after start past aack
// - grant with start gives first ack next
module lookaside_l2_bus_response (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // sensed bus and tag lookup
    input wire lookaside_l2_pkg::bus_in_s bus,
    input wire lookaside_l2_pkg::lookup_s look,
    // address tenure answers
    output logic aack,
    output logic artry,
    output logic hit_claim,
    // data tenure answers
    output logic ta,
    output logic array_write,
    // castout path
    output logic cache_bus_request,
    output logic castout_start,
    output logic cob_load,
    output logic cob_unload,
    // snoop copy maintenance
    output logic snoop_update,
    output logic snoop_invalidate
);

    lookaside_l2_pkg::tenure_e dt_q;
    lookaside_l2_pkg::seq_e sq_q;
    logic [1:0] bc_q;
    logic [1:0] cb_q;
    logic hp_q, mp_q, hw_q, pf_q, pv_q;
    logic cur_wr_q, cur_fill_q, cur_vict_q, sr_q;
    logic aack_q, ta_q, claim_q, artry_q, br_q, cts_q;
    logic aw_q, cobl_q, cobu_q, upd_q, inv_q;

    // classify the transfer start
    logic seq_idle, ts_hit, ts_snp, ts_mem, ts_vict, new_wr;
    assign seq_idle = sq_q == lookaside_l2_pkg::SQ_IDLE;
    assign ts_hit = bus.ts & ~bus.snoop & look.hit
        & ~(~bus.read & bus.write_through_flag);
    assign ts_snp = bus.ts & bus.snoop & look.hit & look.line_dirty
        & seq_idle;
    assign ts_mem = bus.ts & ~ts_hit & ~ts_snp;
    assign ts_vict = bus.ts & ~bus.snoop & ~look.hit & look.victim_dirty
        & seq_idle;
    assign new_wr = ts_hit ? ~bus.read : hw_q;

    // data tenure tracking and pipelining limit
    logic cache_own, last_cache, last_mem, free, want, aack_d;
    logic mem_go, first_beat, ta_d, mem_beat, wr_beat;
    assign cache_own = dt_q == lookaside_l2_pkg::DT_CACHE;
    assign last_cache = cache_own && bc_q == lookaside_l2_pkg::LAST_BEAT;
    assign last_mem = dt_q == lookaside_l2_pkg::DT_MEM && bus.mem_ta
        && bc_q == lookaside_l2_pkg::LAST_BEAT;
    assign free = dt_q == lookaside_l2_pkg::DT_IDLE || last_cache
        || last_mem;
    assign want = ts_hit | hp_q;
    assign aack_d = want & free;
    assign mem_go = (ts_mem | mp_q) & free & ~want;
    assign first_beat = bus.processor_data_bus_grant
        & ((cache_own && bc_q == lookaside_l2_pkg::FIRST_BEAT)
        || (aack_d && dt_q == lookaside_l2_pkg::DT_IDLE));
    assign ta_d = first_beat
        | (cache_own && bc_q != lookaside_l2_pkg::FIRST_BEAT);
    assign mem_beat = dt_q == lookaside_l2_pkg::DT_MEM && bus.mem_ta;
    assign wr_beat = cache_own ? cur_wr_q : new_wr;

    // tenure owner and beat count
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            dt_q <= lookaside_l2_pkg::DT_IDLE;
            bc_q <= 2'h0;
        end else begin
            if (aack_d) begin
                dt_q <= lookaside_l2_pkg::DT_CACHE;
            end else if (mem_go) begin
                dt_q <= lookaside_l2_pkg::DT_MEM;
            end else if (last_cache || last_mem) begin
                dt_q <= lookaside_l2_pkg::DT_IDLE;
            end
            if (ta_d || mem_beat) begin
                bc_q <= bc_q + 2'h1; // wraps after the fourth beat
            end
        end
    end

    // pending pipelined transfer and its attributes
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            hp_q <= 1'b0;
            mp_q <= 1'b0;
            hw_q <= 1'b0;
            pf_q <= 1'b0;
            pv_q <= 1'b0;
            cur_wr_q <= 1'b0;
            cur_fill_q <= 1'b0;
            cur_vict_q <= 1'b0;
        end else begin
            hp_q <= want & ~free;
            mp_q <= (ts_mem | mp_q) & ~mem_go;
            if (ts_hit) begin
                hw_q <= ~bus.read;
            end
            if (ts_mem) begin
                pf_q <= ~bus.snoop & ~look.hit;
                pv_q <= ts_vict;
            end
            if (aack_d) begin
                cur_wr_q <= new_wr;
            end
            if (mem_go) begin
                cur_fill_q <= ts_mem ? (~bus.snoop & ~look.hit) : pf_q;
                cur_vict_q <= ts_mem ? ts_vict : pv_q;
            end
        end
    end

    // address and data answers for hits
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            aack_q <= 1'b0;
            ta_q <= 1'b0;
            claim_q <= 1'b0;
        end else begin
            aack_q <= aack_d;
            ta_q <= ta_d;
            claim_q <= ts_hit | hp_q | aack_d | aack_q;
        end
    end

    // array and copy-back buffer strobes
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            aw_q <= 1'b0;
            cobl_q <= 1'b0;
        end else begin
            aw_q <= (ta_d & wr_beat) | (mem_beat & cur_fill_q);
            cobl_q <= mem_beat & cur_vict_q;
        end
    end

    // castout and snoop sequencer
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sq_q <= lookaside_l2_pkg::SQ_IDLE;
            cb_q <= 2'h0;
            sr_q <= 1'b0;
            artry_q <= 1'b0;
            br_q <= 1'b0;
            cts_q <= 1'b0;
            cobu_q <= 1'b0;
            upd_q <= 1'b0;
            inv_q <= 1'b0;
        end else begin
            cts_q <= 1'b0;
            cobu_q <= 1'b0;
            upd_q <= 1'b0;
            inv_q <= 1'b0;
            case (sq_q)
                lookaside_l2_pkg::SQ_IDLE: begin
                    cb_q <= 2'h0;
                    if (ts_snp) begin
                        sr_q <= bus.read;
                        artry_q <= 1'b1;
                        br_q <= 1'b1;
                        sq_q <= lookaside_l2_pkg::SQ_RETRY;
                    end else if (ts_vict) begin
                        sq_q <= lookaside_l2_pkg::SQ_MISS_DLY;
                    end
                end
                lookaside_l2_pkg::SQ_MISS_DLY: begin
                    br_q <= 1'b1;
                    sq_q <= lookaside_l2_pkg::SQ_MISS_WAIT;
                end
                lookaside_l2_pkg::SQ_MISS_WAIT: begin
                    if (last_mem && cur_vict_q) begin
                        sq_q <= lookaside_l2_pkg::SQ_GRANT;
                    end
                end
                lookaside_l2_pkg::SQ_RETRY: begin
                    if (bus.sys_aack) begin
                        sq_q <= lookaside_l2_pkg::SQ_WINDOW;
                    end
                end
                lookaside_l2_pkg::SQ_WINDOW: begin
                    artry_q <= 1'b0;
                    sq_q <= lookaside_l2_pkg::SQ_REQWIN;
                end
                lookaside_l2_pkg::SQ_REQWIN: begin
                    if (bus.processor_bus_request_sense) begin
                        br_q <= 1'b0;
                        inv_q <= ~sr_q;
                        sq_q <= lookaside_l2_pkg::SQ_YIELD;
                    end else begin
                        sq_q <= lookaside_l2_pkg::SQ_GRANT;
                    end
                end
                lookaside_l2_pkg::SQ_GRANT: begin
                    if (bus.cache_bus_grant) begin
                        br_q <= 1'b0;
                        cts_q <= 1'b1;
                        sq_q <= lookaside_l2_pkg::SQ_CASTOUT;
                    end
                end
                lookaside_l2_pkg::SQ_YIELD: begin
                    if (bus.mem_ta) begin
                        upd_q <= sr_q;
                        cb_q <= cb_q + 2'h1;
                        if (cb_q == lookaside_l2_pkg::LAST_BEAT) begin
                            sq_q <= lookaside_l2_pkg::SQ_IDLE;
                        end
                    end
                end
                lookaside_l2_pkg::SQ_CASTOUT: begin
                    if (bus.mem_ta) begin
                        cobu_q <= 1'b1;
                        cb_q <= cb_q + 2'h1;
                        if (cb_q == lookaside_l2_pkg::LAST_BEAT) begin
                            sq_q <= lookaside_l2_pkg::SQ_IDLE;
                        end
                    end
                end
                default: begin
                    sq_q <= lookaside_l2_pkg::SQ_IDLE;
                end
            endcase
        end
    end

    // outputs straight from flops
    assign aack = aack_q;
    assign artry = artry_q;
    assign hit_claim = claim_q;
    assign ta = ta_q;
    assign array_write = aw_q;
    assign cache_bus_request = br_q;
    assign castout_start = cts_q;
    assign cob_load = cobl_q;
    assign cob_unload = cobu_q;
    assign snoop_update = upd_q;
    assign snoop_invalidate = inv_q;

    // checks on the bus answers
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence s_four_beats;
        ta_q [*4];
    endsequence

    sequence s_retry_tail;
        artry_q ##1 !artry_q;
    endsequence

    a_aack_after_free: assert property (
        aack_q |-> $past(free))
        else $error("aack while data tenure still busy");
    a_aack_with_fourth: assert property (
        last_cache && want |=> aack_q && ta_q)
        else $error("aack not with fourth cache beat");
    a_aack_after_mem: assert property (
        last_mem && hp_q |=> aack_q && !ta_q)
        else $error("aack not one cycle after memory tenure");
    a_write_through_quiet: assert property (
        bus.ts && !bus.snoop && look.hit && !bus.read
        && bus.write_through_flag && seq_idle
        && dt_q == lookaside_l2_pkg::DT_IDLE
        |=> !artry_q && !br_q && !aack_q && !claim_q && !ta_q)
        else $error("write-through hit drove bus signals");
    a_victim_request: assert property (
        ts_vict |=> !br_q ##1 br_q)
        else $error("victim request not two clocks after start");
    a_cob_with_fill: assert property (
        cobl_q |-> aw_q)
        else $error("buffer load without array fill");
    a_retry_window: assert property (
        sq_q == lookaside_l2_pkg::SQ_RETRY && bus.sys_aack
        |=> s_retry_tail)
        else $error("retry window wrong length");
    a_retry_request: assert property (
        ts_snp |=> artry_q && br_q)
        else $error("request did not rise with retry");
    a_grant_phase: assert property (
        sq_q == lookaside_l2_pkg::SQ_REQWIN
        && !bus.processor_bus_request_sense
        |=> sq_q == lookaside_l2_pkg::SQ_GRANT && br_q)
        else $error("grant sampling not entered");
    a_yield_drop: assert property (
        sq_q == lookaside_l2_pkg::SQ_REQWIN
        && bus.processor_bus_request_sense
        |=> !br_q && inv_q == !sr_q)
        else $error("request kept after processor request");
    a_parked_first: assert property (
        ts_hit && dt_q == lookaside_l2_pkg::DT_IDLE
        && bus.processor_data_bus_grant
        |=> (aack_q && claim_q) ##0 s_four_beats)
        else $error("parked hit not answered next cycle");
    a_burst_length: assert property (
        $rose(ta_q) |-> s_four_beats)
        else $error("cache burst shorter than four beats");

endmodule

/* File: hdl/lookaside_l2_pkg.sv */
// shared types and constants for the look-aside cache bus responder
package lookaside_l2_pkg;

    // every cache-side burst is four data beats
    localparam int BURST_BEATS = 4;
    localparam logic [1:0] FIRST_BEAT = 2'h0;
    localparam logic [1:0] LAST_BEAT = 2'(BURST_BEATS - 1);

    // owner of the current data tenure
    typedef enum logic [1:0] {
        DT_IDLE,
        DT_CACHE,
        DT_MEM
    } tenure_e;

    // castout and snoop sequencer
    typedef enum logic [3:0] {
        SQ_IDLE,
        SQ_MISS_DLY,
        SQ_MISS_WAIT,
        SQ_RETRY,
        SQ_WINDOW,
        SQ_REQWIN,
        SQ_GRANT,
        SQ_YIELD,
        SQ_CASTOUT
    } seq_e;

    // bus pins sensed by the cache, all active high here
    typedef struct packed {
        logic ts;
        logic snoop;
        logic read;
        logic write_through_flag;
        logic sys_aack;
        logic mem_ta;
        logic processor_data_bus_grant;
        logic cache_bus_grant;
        logic processor_bus_request_sense;
    } bus_in_s;

    // tag lookup result, valid in the transfer start cycle
    typedef struct packed {
        logic hit;
        logic line_dirty;
        logic victim_dirty;
    } lookup_s;

endpackage

/* File: tb/lookaside_l2_bus_response_tb.sv */
// self-checking bench for the cache bus responder
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin failures++; \
$display("wrong value %s expected %0d seen %0d", nm, e, g); end end

module lookaside_l2_bus_response_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int AK = 10, RT = 9, HC = 8, TA = 7, AW = 6, BR = 5;
    localparam int CO = 4, CL = 3, CU = 2, SU = 1, SI = 0;
    localparam lookaside_l2_pkg::lookup_s HIT = 3'h4, SDIRTY = 3'h6;
    localparam lookaside_l2_pkg::lookup_s CLEAN = 3'h0, DIRTY = 3'h1;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    lookaside_l2_pkg::bus_in_s bq = '0;
    lookaside_l2_pkg::bus_in_s bus;
    lookaside_l2_pkg::lookup_s look = '0;
    lookaside_l2_pkg::lookup_s l2 = '0;
    wire [10:0] o;
    logic mta, gnt;
    logic mstart = 1'b0;
    logic slow = 1'b0;
    logic gall = 1'b0;
    logic two = 1'b0;
    logic strm = 1'b0;
    int failures = 0;
    int n_tests = 0;
    int g_at, a_at, p_at, m_at, lat;
    int first[11], last[11], cnt[11];

    // clock
    always #12.5 core_clk = ~core_clk;

    // bus seen by the cache: bench fields plus the model's answers
    always_comb begin
        bus = bq;
        bus.mem_ta = mta;
        bus.cache_bus_grant = gnt;
    end

    lookaside_l2_bus_response dut (.core_clk(core_clk), .rst(rst),
        .bus(bus), .look(look), .aack(o[AK]), .artry(o[RT]),
        .hit_claim(o[HC]), .ta(o[TA]), .array_write(o[AW]),
        .cache_bus_request(o[BR]), .castout_start(o[CO]), .cob_load(o[CL]),
        .cob_unload(o[CU]), .snoop_update(o[SU]), .snoop_invalidate(o[SI]));

    mem_side_model far (.core_clk(core_clk), .rst(rst), .mem_start(mstart),
        .castout_start(o[CO]), .slow(slow), .cache_bus_request(o[BR]),
        .grant_all(gall), .mem_ta(mta), .cache_bus_grant(gnt));

    // first memory beat of a tenure opened in cycle m
    function automatic int mem_first(input int m);
        return m + lat + 1;
    endfunction

    // transfer start attributes; the flag rides with the start
    function automatic lookaside_l2_pkg::bus_in_s mk(input logic s, r, w);
        lookaside_l2_pkg::bus_in_s b;
        b = '0;
        b.snoop = s;
        b.read = r;
        b.write_through_flag = w;
        return b;
    endfunction

    task automatic sched(input int g, a, p, m);
        g_at = g;
        a_at = a;
        p_at = p;
        m_at = m;
    endtask

    // start at cycle 0, then record first, last and count of each output
    task automatic go(input string nm, input lookaside_l2_pkg::bus_in_s b,
        input lookaside_l2_pkg::lookup_s l, input int n);
        @(posedge core_clk);
        b.ts = 1'b1;
        b.processor_data_bus_grant = (g_at == 0);
        bq <= b;
        look <= l;
        mstart <= (m_at == 0);
        for (int k = 0; k < 11; k++) begin
            first[k] = -1;
            cnt[k] = 0;
        end
        for (int c = 1; c <= n; c++) begin
            @(posedge core_clk);
            bq.ts <= two && c == 1;
            look <= l2;
            bq.processor_data_bus_grant <= strm ? c == 4 : c >= g_at;
            bq.sys_aack <= c == a_at;
            bq.processor_bus_request_sense <= c >= p_at;
            mstart <= c == m_at;
            @(negedge core_clk);
            for (int k = 0; k < 11; k++) begin
                if (o[k] === 1'b1) begin
                    if (first[k] < 0) first[k] = c;
                    last[k] = c;
                    cnt[k]++;
                end
            end
        end
        @(posedge core_clk);
        bq <= '0;
        look <= '0;
        l2 = '0;
        two = 1'b0;
        strm = 1'b0;
        repeat (3) @(posedge core_clk);
        $display("test %s done", nm);
    endtask

    // no bus answer at all
    task automatic quiet();
        for (int k = 4; k <= 10; k++) begin
            if (k != AW) `CHK("silent output", 0, cnt[k])
        end
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // main sequence: random grant delay, direction, ack point; latency alternates 1 and 3
    initial begin
        int g, a;
        logic rd;
        void'($urandom(32'h3a4d738d));
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            g = (i == 0) ? 0 : $urandom_range(3);
            a = 2 + $urandom_range(2);
            rd = 1'($urandom_range(1));
            lat = (i % 2) ? 3 : 1;
            slow <= (i % 2) == 1;
            sched(g, 999, 999, 999);
            go("hit", mk(1'b0, rd, 1'b0), HIT, 12);
            `CHK("claim first", 1, first[HC])
            `CHK("claim last", 2, last[HC])
            `CHK("ta first", g + 1, first[TA])
            `CHK("ta last", g + 4, last[TA])
            `CHK("ta count", 4, cnt[TA])
            sched(0, 999, 999, 0);
            go("wt hit", mk(1'b0, 1'b0, 1'b1), HIT, 12);
            quiet();
            go("clean miss", mk(1'b0, rd, 1'b0), CLEAN, 12);
            quiet();
            go("dirty miss", mk(1'b0, rd, 1'b0), DIRTY, 24);
            `CHK("request first", 2, first[BR])
            `CHK("cob load first", mem_first(0) + 1, first[CL])
            `CHK("array write first", mem_first(0) + 1, first[AW])
            `CHK("cob load count", 4, cnt[CL])
            `CHK("castout after fill", 1, int'(first[CO] > lat + 5))
            `CHK("request drop", first[CO] - 1, last[BR])
            `CHK("unload gap", first[CO] + lat + 2, first[CU])
            `CHK("unload count", 4, cnt[CU])
            sched(0, a, 999, 999);
            go("snoop", mk(1'b1, rd, 1'b0), SDIRTY, 24);
            `CHK("retry first", 1, first[RT])
            `CHK("retry last", a + 1, last[RT])
            `CHK("request with retry", 1, first[BR])
            `CHK("castout start", a + 4, first[CO])
            `CHK("castout beats", 4, cnt[CU])
            gall <= 1'b1;
            sched(0, a, a + 2, a + 3); // processor writes back either way
            go("yield", mk(1'b1, rd, 1'b0), SDIRTY, 24);
            gall <= 1'b0;
            `CHK("request withdrawn", a + 2, last[BR])
            `CHK("grant ignored", 0, cnt[CO])
            `CHK("update", rd ? 4 : 0, cnt[SU])
            `CHK("invalidate", rd ? 0 : 1, cnt[SI])
            sched(0, 999, 999, 999);
            two = 1'b1;
            l2 = HIT;
            strm = 1'b1;
            go("pipelined hits", mk(1'b0, rd, 1'b0), HIT, 16);
            `CHK("streamed last ta", 8, last[TA])
            `CHK("aack count", 2, cnt[AK])
            `CHK("aack with fourth ta", 4, last[AK])
            `CHK("ta count two bursts", 8, cnt[TA])
            sched(0, 999, 999, 0);
            two = 1'b1;
            l2 = HIT;
            go("miss then hit", mk(1'b0, rd, 1'b0), CLEAN, 20);
            `CHK("aack after miss", mem_first(0) + 4, first[AK])
            `CHK("aack once", 1, cnt[AK])
        end
        complete_run();
    end

    // watchdog: well beyond six rounds of about 184 cycles each
    initial begin
        repeat (6000) @(posedge core_clk);
        failures++;
        complete_run();
    end
endmodule

/* File: tb/mem_side_model.sv */
// memory controller and bus arbiter model on the far side of the cache
module mem_side_model (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // tenure starts and latency choice
    input wire logic mem_start,
    input wire logic castout_start,
    input wire logic slow,
    // arbitration
    input wire logic cache_bus_request,
    input wire logic grant_all,
    // answers to the cache
    output logic mem_ta,
    output logic cache_bus_grant
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] wait_q;
    logic [2:0] beats_q;

    // wait state count, then four back-to-back beats
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wait_q <= 2'h0;
            beats_q <= 3'h0;
        end else if (mem_start || castout_start) begin
            wait_q <= slow ? 2'h3 : 2'h1;
            beats_q <= 3'h4;
        end else if (wait_q != 2'h0) begin
            wait_q <= wait_q - 2'h1;
        end else if (beats_q != 3'h0) begin
            beats_q <= beats_q - 3'h1;
        end
    end
    assign mem_ta = (wait_q == 2'h0) && (beats_q != 3'h0);

    // grant follows the request a cycle later, or is forced on
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cache_bus_grant <= 1'b0;
        end else begin
            cache_bus_grant <= cache_bus_request | grant_all;
        end
    end
endmodule
